// ==== tti_insert_timing.v ====
// Teletext request, capture and insertion timing with APB registers
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/100ps
`include "tti_defines.vh"
module tti_insert_timing #(
   parameter MAX_BITS = `TTI_BITS_625
)(
   // Clock and reset
   input wire clock,
   input wire sys_rst,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Video timing from encoder, same clock
   input wire hsyncLead,
   input wire oddField,
   input wire [8:0] lineNumber,
   // Teletext source pins
   input wire teletextSerialInput,
   output reg textBitRequest,
   // Insertion towards composite and luma paths
   output reg cvbsTextInsert,
   output reg vbsTextInsert,
   output reg [7:0] textLevel
);
   // Start offsets from sync lead in clock cycles, rounded down
   localparam [31:0] START_625_W = (`TTI_START_625_NS * (`TTI_CLK_HZ / 1000000)) / 1000;
   localparam [31:0] START_525_W = (`TTI_START_525_NS * (`TTI_CLK_HZ / 1000000)) / 1000;
   localparam [10:0] START_625 = START_625_W[10:0];
   localparam [10:0] START_525 = START_525_W[10:0];
   localparam [63:0] INC_625_W = (64'd1 << `TTI_ACC_BITS) * `TTI_RATE_625_HZ / `TTI_CLK_HZ;
   localparam [63:0] INC_525_W = (64'd1 << `TTI_ACC_BITS) * `TTI_RATE_525_HZ / `TTI_CLK_HZ;
   localparam [`TTI_ACC_BITS-1:0] INC_625 = INC_625_W[`TTI_ACC_BITS-1:0];
   localparam [`TTI_ACC_BITS-1:0] INC_525 = INC_525_W[`TTI_ACC_BITS-1:0];
   // Window lengths cut to the bit index width
   localparam [31:0] BITS_625_W = `TTI_BITS_625;
   localparam [31:0] BITS_WST_W = `TTI_BITS_WST;
   localparam [31:0] BITS_NABTS_W = `TTI_BITS_NABTS;
   localparam [8:0] BITS_625 = BITS_625_W[8:0];
   localparam [8:0] BITS_WST = BITS_WST_W[8:0];
   localparam [8:0] BITS_NABTS = BITS_NABTS_W[8:0];

   // Register fields
   reg [7:0] ctrlReg;
   reg [7:0] requestHorizontalStart;
   reg [3:0] sourcePipelineDelay;
   reg [7:0] oddFirstLo;
   reg [7:0] oddLastLo;
   reg [7:0] evenFirstLo;
   reg [7:0] evenLastLo;
   reg [7:0] modeReg;

   // Line and window state
   reg [10:0] hCount;
   reg lineOk;
   reg [18:0] reqPipe;
   // Tap past the source delay, its output register and our two sync flops
   wire [4:0] captureTap = {1'b0, sourcePipelineDelay} + 5'h03;
   reg serialMeta;
   reg serialSync;
   reg [8:0] writeIndex;
   reg [8:0] capturedCount;
   reg bitMem [0:MAX_BITS-1];
   reg curBit;
   reg prevBit;

   wire teletextInsertEnable = ctrlReg[`TTI_CTRL_ENABLE];
   wire mode525 = modeReg[`TTI_MODE_525];
   wire [8:0] oddFieldFirstLine = {modeReg[`TTI_MODE_ODD_FIRST_MSB], oddFirstLo};
   wire [8:0] oddFieldLastLine = {modeReg[`TTI_MODE_ODD_LAST_MSB], oddLastLo};
   wire [8:0] evenFieldFirstLine = {modeReg[`TTI_MODE_EVEN_FIRST_MSB], evenFirstLo};
   wire [8:0] evenFieldLastLine = {modeReg[`TTI_MODE_EVEN_LAST_MSB], evenLastLo};

   // ==========================================
   // Standard selection
   // Rate and window length follow the mode bits
   wire [`TTI_ACC_BITS-1:0] bitIncrement = mode525 ? INC_525 : INC_625;
   wire [8:0] windowBits = !mode525 ? BITS_625 :
      (modeReg[`TTI_MODE_NABTS] ? BITS_NABTS : BITS_WST);
   wire [10:0] insertStart = mode525 ? START_525 : START_625;
   wire [10:0] requestStart = {1'b0, requestHorizontalStart, 2'b00};

   // Line lies inside the programmed range of its field
   function inRange;
      input [8:0] line;
      input [8:0] first;
      input [8:0] last;
      begin
         inRange = (line >= first) && (line <= last);
      end
   endfunction

   wire lineSelected = oddField ? inRange(lineNumber, oddFieldFirstLine, oddFieldLastLine)
      : inRange(lineNumber, evenFieldFirstLine, evenFieldLastLine);

   // ==========================================
   // Horizontal position and line qualification
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         hCount <= 11'h000;
         lineOk <= 1'b0;
      end
      else if (hsyncLead)
      begin
         hCount <= 11'h000;
         lineOk <= teletextInsertEnable && lineSelected;
      end
      else
      begin
         if (hCount != 11'h7FF)
            hCount <= hCount + 11'h001;
         if (!teletextInsertEnable)
            lineOk <= 1'b0;
      end
   end

   wire reqStartPulse = lineOk && !hsyncLead && hCount == requestStart;
   wire insStartPulse = lineOk && !hsyncLead && hCount == insertStart;
   wire reqActive;
   wire reqTick;
   wire insActive;
   wire insTick;
   wire [8:0] insIndex;
   wire [7:0] insPhase;

   // ==========================================
   // Request pacing and playout pacing
   tti_bit_timer #(.ACC_BITS(`TTI_ACC_BITS)) requestTimer (
      .clock(clock),
      .sys_rst(sys_rst),
      .start(reqStartPulse),
      .increment(bitIncrement),
      .bitCount(windowBits),
      .active(reqActive),
      .bitTick(reqTick),
      .bitIndex(),
      .phase()
   );

   tti_bit_timer #(.ACC_BITS(`TTI_ACC_BITS)) insertTimer (
      .clock(clock),
      .sys_rst(sys_rst),
      .start(insStartPulse),
      .increment(bitIncrement),
      .bitCount(windowBits),
      .active(insActive),
      .bitTick(insTick),
      .bitIndex(insIndex),
      .phase(insPhase)
   );

   // ==========================================
   // Request pin and source data capture
   // Request pulses are delayed to a tap three stages past the programmed pipeline delay before sampling
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         textBitRequest <= 1'b0;
         reqPipe <= 19'h00000;
         serialMeta <= 1'b0;
         serialSync <= 1'b0;
         writeIndex <= 9'h000;
         capturedCount <= 9'h000;
      end
      else
      begin
         textBitRequest <= reqTick && lineOk;
         reqPipe <= {reqPipe[17:0], textBitRequest};
         serialMeta <= teletextSerialInput;
         serialSync <= serialMeta;
         if (reqStartPulse)
            writeIndex <= 9'h000;
         else if (reqPipe[captureTap] && writeIndex < MAX_BITS)
         begin
            bitMem[writeIndex] <= serialSync;
            writeIndex <= writeIndex + 9'h001;
            capturedCount <= writeIndex + 9'h001;
         end
      end
   end

   // ==========================================
   // Interpolated insertion into both video paths
   // Linear ramp between neighbouring bits softens edges in the output
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         curBit <= 1'b0;
         prevBit <= 1'b0;
         cvbsTextInsert <= 1'b0;
         vbsTextInsert <= 1'b0;
         textLevel <= 8'h00;
      end
      else
      begin
         if (insTick)
         begin
            prevBit <= curBit;
            curBit <= bitMem[insIndex];
         end
         cvbsTextInsert <= insActive && lineOk;
         vbsTextInsert <= insActive && lineOk;
         if (!(insActive && lineOk))
            textLevel <= 8'h00;
         else if (prevBit == curBit)
            textLevel <= curBit ? 8'hFF : 8'h00;
         else
            textLevel <= curBit ? insPhase : ~insPhase;
      end
   end

   // ==========================================
   // APB slave: one wait state, write lands on the completing edge
   wire [9:0] regIndex = paddr[11:2];
   wire apbDone = psel && penable && pready;

   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         ctrlReg <= `TTI_RST_BYTE;
         requestHorizontalStart <= `TTI_RST_BYTE;
         sourcePipelineDelay <= 4'h0;
         oddFirstLo <= `TTI_RST_BYTE;
         oddLastLo <= `TTI_RST_BYTE;
         evenFirstLo <= `TTI_RST_BYTE;
         evenLastLo <= `TTI_RST_BYTE;
         modeReg <= `TTI_RST_BYTE;
      end
      else if (psel && penable && !pready)
      begin
         pready <= 1'b1;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (regIndex == `TTI_IDX_CTRL)
            prdata <= {24'h000000, ctrlReg};
         else if (regIndex == `TTI_IDX_HSTART)
            prdata <= {24'h000000, requestHorizontalStart};
         else if (regIndex == `TTI_IDX_HDELAY)
            prdata <= {28'h0000000, sourcePipelineDelay};
         else if (regIndex == `TTI_IDX_ODD_FIRST)
            prdata <= {24'h000000, oddFirstLo};
         else if (regIndex == `TTI_IDX_ODD_LAST)
            prdata <= {24'h000000, oddLastLo};
         else if (regIndex == `TTI_IDX_EVEN_FIRST)
            prdata <= {24'h000000, evenFirstLo};
         else if (regIndex == `TTI_IDX_EVEN_LAST)
            prdata <= {24'h000000, evenLastLo};
         else if (regIndex == `TTI_IDX_MODE)
            prdata <= {24'h000000, modeReg};
         else if (regIndex == `TTI_IDX_STATUS)
            prdata <= {19'h00000, capturedCount, 1'b0, insActive, reqActive, lineOk};
         else
            pslverr <= 1'b1;
      end
      else if (apbDone)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         if (pwrite && !pslverr)
         begin
            if (regIndex == `TTI_IDX_CTRL)
               ctrlReg <= pwdata[7:0];
            else if (regIndex == `TTI_IDX_HSTART)
               requestHorizontalStart <= pwdata[7:0];
            else if (regIndex == `TTI_IDX_HDELAY)
               sourcePipelineDelay <= pwdata[3:0];
            else if (regIndex == `TTI_IDX_ODD_FIRST)
               oddFirstLo <= pwdata[7:0];
            else if (regIndex == `TTI_IDX_ODD_LAST)
               oddLastLo <= pwdata[7:0];
            else if (regIndex == `TTI_IDX_EVEN_FIRST)
               evenFirstLo <= pwdata[7:0];
            else if (regIndex == `TTI_IDX_EVEN_LAST)
               evenLastLo <= pwdata[7:0];
            else if (regIndex == `TTI_IDX_MODE)
               modeReg <= pwdata[7:0];
         end
      end
      else
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end
endmodule

// ==== tti_defines.vh ====
// Constants for the teletext insertion timing block
// Functional notes
// - Inserted text starts 9.78 us (625) or 10.5 us (525) after sync lead.
// - Received bits are interpolated and inserted into composite and luma outputs.
// - A programmed delay compensates the source pipeline from request to data.
// - Request start and request-to-data delay are both programmable.
// - 625-line window holds 360 bits at 6.9375 Mbit/s.
// - World-standard window holds 296 bits at 5.7272 Mbit/s.
// - North American format window holds 288 bits at 5.7272 Mbit/s.
// - Window stays closed while the enable bit is zero.
// - Odd and even fields each have programmable first and last lines.
// - Delay field is four bits, low nibble at 74, upper nibble unused.
// - Request start field is eight bits, whole register at 73.
// - Odd first line is nine bits: low byte at 76, ninth in MSB register.
// - Enable bit sits at 6F with caption enable and line select.
`ifndef TTI_DEFINES_VH
`define TTI_DEFINES_VH

// ==========================================
// Register indices (byte address is four times the index)
`define TTI_IDX_CTRL 8'h6F
`define TTI_IDX_HSTART 8'h73
`define TTI_IDX_HDELAY 8'h74
`define TTI_IDX_ODD_FIRST 8'h76
`define TTI_IDX_ODD_LAST 8'h77
`define TTI_IDX_EVEN_FIRST 8'h78
`define TTI_IDX_EVEN_LAST 8'h79
`define TTI_IDX_MODE 8'h7C
`define TTI_IDX_STATUS 8'hA0

// ==========================================
// Field positions
`define TTI_CTRL_ENABLE 5
`define TTI_MODE_ODD_FIRST_MSB 0
`define TTI_MODE_EVEN_FIRST_MSB 1
`define TTI_MODE_ODD_LAST_MSB 2
`define TTI_MODE_EVEN_LAST_MSB 3
`define TTI_MODE_NABTS 5
`define TTI_MODE_525 7

// ==========================================
// Reset values
`define TTI_RST_BYTE 8'h00

// ==========================================
// Timing
`define TTI_CLK_HZ 100000000
`define TTI_START_625_NS 9780
`define TTI_START_525_NS 10500
`define TTI_RATE_625_HZ 6937500
`define TTI_RATE_525_HZ 5727200
`define TTI_BITS_625 360
`define TTI_BITS_WST 296
`define TTI_BITS_NABTS 288
`define TTI_HSTART_UNIT 4
`define TTI_ACC_BITS 16

`endif

// ==== tti_bit_timer.v ====
// Bit-rate timer that paces a fixed number of bit slots
`timescale 1ns/100ps
module tti_bit_timer #(
   parameter ACC_BITS = 16
)(
   // Clock and reset
   input wire clock,
   input wire sys_rst,
   // Control
   input wire start,
   input wire [ACC_BITS-1:0] increment,
   input wire [8:0] bitCount,
   // Status
   output reg active,
   output reg bitTick,
   output reg [8:0] bitIndex,
   output wire [7:0] phase
);
   reg [ACC_BITS-1:0] acc;
   wire [ACC_BITS:0] sum = {1'b0, acc} + {1'b0, increment};

   assign phase = acc[ACC_BITS-1:ACC_BITS-8];

   // ==========================================
   // Phase accumulator; start marks the first bit slot, carry each later one
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         active <= 1'b0;
         bitTick <= 1'b0;
         bitIndex <= 9'h000;
         acc <= {ACC_BITS{1'b0}};
      end
      else if (start)
      begin
         active <= 1'b1;
         bitTick <= 1'b1;
         bitIndex <= 9'h000;
         acc <= {ACC_BITS{1'b0}};
      end
      else if (active)
      begin
         acc <= sum[ACC_BITS-1:0];
         if (sum[ACC_BITS] && bitIndex == bitCount - 9'h001)
         begin
            active <= 1'b0;
            bitTick <= 1'b0;
         end
         else if (sum[ACC_BITS])
         begin
            bitIndex <= bitIndex + 9'h001;
            bitTick <= 1'b1;
         end
         else
            bitTick <= 1'b0;
      end
      else
         bitTick <= 1'b0;
   end
endmodule

// ==== tti_text_source.sv ====
// Behavioural model of the external teletext serial data source
`timescale 1ns/100ps
module tti_text_source (
   // Clock
   input wire clock,
   // Request from the block and the source's own pipeline delay
   input wire textBitRequest,
   input wire [3:0] pipeDelay,
   // Serial text data
   output reg teletextSerialInput
);
reg [15:0] reqPipe;
initial
begin
   reqPipe = 16'h0000;
   teletextSerialInput = 1'b0;
end
// One fresh random bit per request, late by the pipeline delay
always @(posedge clock)
begin
   reqPipe <= {reqPipe[14:0], textBitRequest};
   if (reqPipe[pipeDelay])
      teletextSerialInput <= 1'($urandom);
end
endmodule

// ==== tti_insert_timing_chk.sv ====
// Concurrent checks on the ports of the teletext insertion timing block
`timescale 1ns/100ps
`include "tti_defines.vh"
module tti_insert_timing_chk #(
   parameter MAX_BITS = 360
)(
   // Clock and reset
   input wire clock,
   input wire sys_rst,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Video timing and text path
   input wire hsyncLead,
   input wire textBitRequest,
   input wire cvbsTextInsert,
   input wire vbsTextInsert,
   input wire [7:0] textLevel
);
default clocking @(posedge clock); endclocking
default disable iff (sys_rst);
reg enShadow;
reg enLate;
reg enLater;
reg [12:0] hc;
// ==========================================
// Helpers
// Enable shadow lags two cycles: line qualification and outputs are both registered
always @(posedge clock)
begin
   if (sys_rst)
   begin
      enShadow <= 1'b0;
      enLate <= 1'b0;
      enLater <= 1'b0;
      hc <= 13'h0000;
   end
   else
   begin
      if (psel && penable && pready && pwrite && paddr == {2'b00, `TTI_IDX_CTRL, 2'b00})
         enShadow <= pwdata[`TTI_CTRL_ENABLE];
      enLate <= enShadow;
      enLater <= enLate;
      hc <= hsyncLead ? 13'h0000 : hc + {12'h000, hc != 13'h1FFF};
   end
end
// ==========================================
// Assertions
sequence accessWait;
   psel && penable && !pready;
endsequence
sequence oneAnswer;
   pready ##1 !pready;
endsequence
chk_apb_answer: assert property (accessWait |=> oneAnswer)
   else $error("APB answer late or longer than one cycle");
chk_err_clean: assert property (pslverr |-> pready && prdata == 32'h00000000)
   else $error("Error response without ready or with data");
chk_req_spacing: assert property (textBitRequest |=> !textBitRequest [*8])
   else $error("Request pulse too long or too close");
chk_closed_idle: assert property (!enShadow && !enLate && !enLater |-> !textBitRequest && !cvbsTextInsert)
   else $error("Request or insertion while disabled");
chk_insert_both: assert property (cvbsTextInsert |-> vbsTextInsert)
   else $error("Composite insertion without luma insertion");
chk_insert_luma: assert property ($rose(vbsTextInsert) |-> $rose(cvbsTextInsert))
   else $error("Luma insertion opened alone");
chk_level_idle: assert property (!cvbsTextInsert |-> textLevel == 8'h00)
   else $error("Text level outside the window");
chk_insert_start: assert property ($rose(cvbsTextInsert) |-> hc inside {[978:980], [1050:1052]})
   else $error("Insertion window opened at wrong position");
endmodule
bind tti_insert_timing tti_insert_timing_chk #(.MAX_BITS(MAX_BITS)) chk_u (
   .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .hsyncLead(hsyncLead), .textBitRequest(textBitRequest), .cvbsTextInsert(cvbsTextInsert),
   .vbsTextInsert(vbsTextInsert), .textLevel(textLevel));

// ==== tti_insert_timing_test.sv ====
// Self-checking bench for the teletext insertion timing block
`timescale 1ns/100ps
`include "tti_defines.vh"
module tti_insert_timing_test;
reg clock, sys_rst, psel, penable, pwrite, hsyncLead, oddField;
reg [11:0] paddr;
reg [31:0] pwdata;
reg [8:0] lineNumber;
reg [3:0] pipeDelay;
wire [31:0] prdata;
wire [7:0] textLevel;
wire pready, pslverr, teletextSerialInput, textBitRequest, cvbsTextInsert, vbsTextInsert;
int fails = 0, cmp_count = 0, cyc = 0, m, i;
logic [33:0] aq[$];
logic [31:0] lq[$];
logic [33:0] e;
logic [31:0] reqCnt = 0, r;
bit armed = 0;
bit cvbsPrev = 0;
logic [31:0] winCnt = 0, x;
logic [8:0] oddFirst;
logic [7:0] evenLine;
logic [7:0] modeSet[3] = '{8'h05, 8'h85, 8'hA5};
int bitsSet[3] = '{`TTI_BITS_625, `TTI_BITS_WST, `TTI_BITS_NABTS};
logic [7:0] regIdx[9] = '{`TTI_IDX_CTRL, `TTI_IDX_HSTART, `TTI_IDX_HDELAY, `TTI_IDX_ODD_FIRST,
   `TTI_IDX_ODD_LAST, `TTI_IDX_EVEN_FIRST, `TTI_IDX_EVEN_LAST, `TTI_IDX_MODE, `TTI_IDX_STATUS};
tti_insert_timing dut_u (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .hsyncLead(hsyncLead), .oddField(oddField), .lineNumber(lineNumber),
   .teletextSerialInput(teletextSerialInput), .textBitRequest(textBitRequest),
   .cvbsTextInsert(cvbsTextInsert), .vbsTextInsert(vbsTextInsert), .textLevel(textLevel));
tti_text_source src_u (.clock(clock), .textBitRequest(textBitRequest), .pipeDelay(pipeDelay),
   .teletextSerialInput(teletextSerialInput));
// ==========================================
// Tasks
task cmp(input logic [31:0] got, input logic [31:0] exp);
begin
   cmp_count++;
   if (got !== exp)
   begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
   end
end
endtask
task finish_test;
begin
   if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
   else
      $display("Checks failed");
   $finish;
end
endtask
// One APB transfer; the monitor checks the answer against the note
task apb(input [7:0] idx, input wr, input [31:0] wd, input [31:0] ed, input ee);
begin
   @(posedge clock);
   aq.push_back({!wr, ee, ed});
   psel <= 1;
   penable <= 0;
   pwrite <= wr;
   paddr <= {2'b00, idx, 2'b00};
   pwdata <= wd;
   @(posedge clock);
   penable <= 1;
   do @(posedge clock); while (pready !== 1'b1);
   psel <= 0;
   penable <= 0;
end
endtask
// One video line; expected request count is noted before the sync pulse
task line(input odd, input [8:0] num, input [31:0] exp);
begin
   lq.push_back(exp);
   oddField <= odd;
   lineNumber <= num;
   hsyncLead <= 1;
   @(posedge clock);
   hsyncLead <= 0;
   repeat (6300) @(posedge clock);
end
endtask
// ==========================================
// Clock, timeout and monitor
always #5 clock = ~clock;
// Requests are counted per line, the count is checked at the next sync
always @(posedge clock)
begin
   cyc++;
   if (cyc == 76000)
   begin
      fails++;
      finish_test;
   end
   if (pready === 1'b1)
   begin
      e = aq.pop_front();
      cmp({31'h00000000, pslverr}, {31'h00000000, e[32]});
      if (e[33])
         cmp(prdata, e[31:0]);
   end
   if (hsyncLead === 1'b1)
   begin
      if (armed)
      begin
         x = lq.pop_front();
         cmp(reqCnt, x);
         cmp(winCnt, {31'h00000000, x != 0});
      end
      armed = 1;
      reqCnt = 0;
      winCnt = 0;
   end
   else if (textBitRequest === 1'b1)
      reqCnt++;
   // One insertion window is expected on each qualified line
   if (cvbsTextInsert === 1'b1 && !cvbsPrev)
      winCnt++;
   cvbsPrev = (cvbsTextInsert === 1'b1);
end
// ==========================================
// Main sequence
initial
begin
   clock = 0;
   sys_rst = 1;
   {psel, penable, pwrite, hsyncLead, oddField} = 5'h00;
   paddr = 12'h000;
   pwdata = 32'h00000000;
   lineNumber = 9'h000;
   pipeDelay = 4'h0;
   r = $urandom(90484);
   repeat (5) @(posedge clock);
   sys_rst <= 0;
   for (i = 0; i < 9; i++)
      apb(regIdx[i], 0, 0, 0, 0);
   apb(8'h01, 1, 32'hFFFFFFFF, 0, 1);
   apb(8'h01, 0, 0, 0, 1);
   apb(`TTI_IDX_HDELAY, 1, 32'h000000FF, 0, 0);
   apb(`TTI_IDX_HDELAY, 0, 0, 32'h0000000F, 0);
   pipeDelay <= 4'($urandom);
   @(posedge clock);
   apb(`TTI_IDX_HDELAY, 1, {28'h0000000, pipeDelay}, 0, 0);
   r = $urandom;
   apb(`TTI_IDX_HSTART, 1, r, 0, 0);
   apb(`TTI_IDX_HSTART, 0, 0, {24'h000000, r[7:0]}, 0);
   oddFirst = 9'h100 + 9'($urandom % 16);
   evenLine = 8'h10 + 8'($urandom % 64);
   apb(`TTI_IDX_ODD_FIRST, 1, {24'h000000, oddFirst[7:0]}, 0, 0);
   apb(`TTI_IDX_ODD_LAST, 1, {24'h000000, oddFirst[7:0] + 8'h02}, 0, 0);
   apb(`TTI_IDX_EVEN_FIRST, 1, {24'h000000, evenLine}, 0, 0);
   apb(`TTI_IDX_EVEN_LAST, 1, {24'h000000, evenLine}, 0, 0);
   // Every standard: inside odd range, even single line, just past odd range
   for (m = 0; m < 3; m++)
   begin
      apb(`TTI_IDX_MODE, 1, {24'h000000, modeSet[m]}, 0, 0);
      apb(`TTI_IDX_MODE, 0, 0, {24'h000000, modeSet[m]}, 0);
      r = ($urandom & 32'h000000FF) | 32'h00000020;
      apb(`TTI_IDX_CTRL, 1, r, 0, 0);
      apb(`TTI_IDX_CTRL, 0, 0, r, 0);
      line(1, oddFirst + 9'h001, bitsSet[m]);
      line(0, {1'b0, evenLine}, bitsSet[m]);
      line(1, oddFirst + 9'h003, 0);
      apb(`TTI_IDX_STATUS, 0, 0, {19'h00000, 9'(bitsSet[m]), 4'h0}, 0);
   end
   apb(`TTI_IDX_CTRL, 1, 32'h000000DF, 0, 0);
   line(1, oddFirst + 9'h001, 0);
   line(0, 9'h000, 0);
   finish_test;
end
endmodule
